// [hdl/fcpm_pkg.sv]
// Package for the four-channel pulse modulator: map, fields, types
package fcpm_pkg;
  localparam int NCH         = 4;
  localparam int CW          = 16;
  localparam int NPRE        = 11;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_DIVCFG  = 8'h00;
  localparam logic [7:0] OFS_ENA     = 8'h04;
  localparam logic [7:0] OFS_DIS     = 8'h08;
  localparam logic [7:0] OFS_STAT    = 8'h0C;
  localparam logic [7:0] OFS_IEN     = 8'h10;
  localparam logic [7:0] OFS_IDIS    = 8'h14;
  localparam logic [7:0] OFS_IMASK   = 8'h18;
  localparam logic [7:0] OFS_EVSTAT  = 8'h1C;
  localparam logic [7:0] OFS_CLKRUN  = 8'h20;
  localparam logic [7:0] OFS_CH_BASE = 8'h40;
  localparam logic [7:0] OFS_CH_STEP = 8'h10;
  // Per-channel word offsets within the channel block
  localparam logic [3:0] CH_MODE     = 4'h0;
  localparam logic [3:0] CH_DUTY     = 4'h4;
  localparam logic [3:0] CH_PERIOD   = 4'h8;
  localparam logic [3:0] CH_UPDATE   = 4'hC;
  // Divider config field positions
  localparam int LINEAR_DIVIDE_A_LSB    = 0;
  localparam int PRESCALE_SELECT_A_LSB    = 8;
  localparam int LINEAR_DIVIDE_B_LSB    = 16;
  localparam int PRESCALE_SELECT_B_LSB    = 24;
  // Channel mode field positions
  localparam int SEL_LSB     = 0;
  localparam int ALIGN_BIT   = 8;
  localparam int POL_BIT     = 9;
  localparam int UPD_BIT     = 10;
  // Clock selector codes beyond the eleven divisions
  localparam logic [3:0] SEL_LINEAR_DIVIDE_A = 4'hB;
  localparam logic [3:0] SEL_LINEAR_DIVIDE_B = 4'hC;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] sel;
    logic       center;
    logic       start_high;
    logic       upd_period;
  } fcpm_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic       wr;
    logic       rd;
  } fcpm_bus_t;
endpackage

// [hdl/fcpm_top.sv]
// Four-channel pulse modulator: clock generator, channels, registers
`timescale 1ns/100ps
// What this block does
// - Four independent channels, each driving one waveform output line.
// - Each channel has its own 16-bit counter.
// - Clock generator offers thirteen selectable clocks to the channels.
// - Free-running counter yields master clock divided by 1 up to 1024.
// - Two linear dividers divide by 1 to 255, giving clocks A and B.
// - Linear divider divides selected prescaler output by its factor.
// - Reset clears prescaler selects and divide factors; A and B stop.
// - In reset only undivided prescaler output active; clock gated, none.
// - Each channel independently selects any generator clock.
// - Channel counter steps on selected clock, up or up/down.
// - Comparator raises events and forms the output waveform.
// - Period or duty changes are double buffered while running.
// - Each channel enabled and disabled by its own command.
// - Programmable polarity sets the waveform starting level.
// - Each channel can be left aligned or center aligned.
// - Channels enabled together start in step.
// - All software access is through memory-mapped registers.
// - Configuration writes accepted even while controller clock gated.
// - After clock gating, counters and outputs resume exactly.
// - Center: up to period then down to zero; left: up then reset.
// - Update value held until period end (applied at once while disabled), then loads period or duty.
// - Unmasked period end raises interrupt until status read clears it.
// - Polarity writes ignored while enabled; default start level low.
module fcpm_top #(
  parameter int NCH = fcpm_pkg::NCH
) (
  input  wire logic           CLOCK,      // 200 MHz system clock
  input  wire logic           NRST,       // Async reset, active low
  input  wire logic           CLK_EN,     // Master clock gate from power manager
  input  wire logic [7:0]     ADDR,       // Register byte address
  input  wire logic [31:0]    WDATA,      // Write data
  input  wire logic           WR,         // Write strobe
  input  wire logic           RD,         // Read strobe
  output logic      [31:0]    RDATA,      // Read data, cycle after RD
  output logic                IRQ,        // Level interrupt
  output logic      [NCH-1:0] MODULATED_WAVE_OUT // Channel waveforms
);
  localparam int CW = fcpm_pkg::CW;
  localparam int NP = fcpm_pkg::NPRE;

  // Enable, mask and status words hold at most four channel bits
  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("NCH must be 1..4");
  end

  fcpm_pkg::fcpm_bus_t bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [31:0]          divider_config_reg_r;
  logic [NCH-1:0]       ch_en_r;
  logic [NCH-1:0]       channel_event_mask_r;
  logic [NCH-1:0]       channel_event_status_r;
  fcpm_pkg::fcpm_mode_t mode_r   [NCH];
  logic [CW-1:0]        period_value_r [NCH];
  logic [CW-1:0]        duty_value_r   [NCH];
  logic [CW-1:0]        upd_hold_r     [NCH];
  logic [NCH-1:0]       upd_pend_r;
  logic [CW-1:0]        cnt_r    [NCH];
  logic [NCH-1:0]       down_r;
  logic [NCH-1:0]       wave_r;
  logic [NCH-1:0]       period_end;
  logic [NCH-1:0]       tick;

  // Decode a channel register address
  function automatic logic ch_hit(input logic [7:0] a, input int c,
                                  input logic [3:0] w);
    logic [7:0] base;
    base = 8'(fcpm_pkg::OFS_CH_BASE + 8'(c) * fcpm_pkg::OFS_CH_STEP);
    return a == (base | {4'h0, w});
  endfunction

  // Prescaler: gated by CLK_EN so state freezes while stopped
  logic [9:0]    pre_cnt_r;
  logic [NP-1:0] pre_tick;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pre_cnt_r <= 10'h000;
    end else if (CLK_EN) begin
      pre_cnt_r <= pre_cnt_r + 10'h001;
    end
  end

  always_comb begin
    pre_tick[0] = CLK_EN;
    for (int k = 1; k < NP; k++) begin
      // Divide by 2^k: one pulse when low k bits are all ones
      pre_tick[k] = CLK_EN && (&(pre_cnt_r | ~(10'((1 << k) - 1))));
    end
  end

  // Linear dividers A and B
  logic [7:0] lin_cnt_r [2];
  logic [1:0] lin_tick;
  logic [7:0] lin_div [2];
  logic [3:0] lin_pre [2];
  assign lin_div[0] = divider_config_reg_r[fcpm_pkg::LINEAR_DIVIDE_A_LSB +: 8];
  assign lin_div[1] = divider_config_reg_r[fcpm_pkg::LINEAR_DIVIDE_B_LSB +: 8];
  assign lin_pre[0] = divider_config_reg_r[fcpm_pkg::PRESCALE_SELECT_A_LSB +: 4];
  assign lin_pre[1] = divider_config_reg_r[fcpm_pkg::PRESCALE_SELECT_B_LSB +: 4];

  for (genvar d = 0; d < 2; d++) begin : g_lin
    logic src;
    assign src = (lin_pre[d] < 4'(NP)) ? pre_tick[lin_pre[d]]
                                        : 1'b0;
    // Zero factor stops the divided clock
    assign lin_tick[d] = src && (lin_div[d] != 8'h00) &&
                         (lin_cnt_r[d] + 8'h01 >= lin_div[d]);
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        lin_cnt_r[d] <= 8'h00;
      end else if (src) begin
        lin_cnt_r[d] <= lin_tick[d] ? 8'h00 : lin_cnt_r[d] + 8'h01;
      end
    end
  end

  // Per-channel clock selection, counter and comparator
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [3:0] sel;
    logic       at_top;
    logic       at_last;
    logic       turn_down;
    logic       up_hit;
    logic       down_hit;
    assign sel = mode_r[c].sel;
    always_comb begin
      unique case (sel)
        fcpm_pkg::SEL_LINEAR_DIVIDE_A: tick[c] = lin_tick[0];
        fcpm_pkg::SEL_LINEAR_DIVIDE_B: tick[c] = lin_tick[1];
        default: tick[c] = (sel < 4'(NP)) ? pre_tick[sel] : 1'b0;
      endcase
    end
    assign at_top = cnt_r[c] >= period_value_r[c];
    // Left aligned wraps after period-1, so one period is period ticks
    assign at_last = cnt_r[c] + 16'h0001 >= period_value_r[c];
    // Next tick moves down: already falling, or turning at the top
    assign turn_down = down_r[c] || (mode_r[c].center && at_top);
    assign up_hit = !turn_down && cnt_r[c] + 16'h0001 == duty_value_r[c];
    // Mirror of the up match, so both halves keep the same start time
    assign down_hit = turn_down && cnt_r[c] - 16'h0001 <= duty_value_r[c];
    assign period_end[c] = ch_en_r[c] && tick[c] &&
      (mode_r[c].center ? (down_r[c] && cnt_r[c] <= 16'h0001)
                        : at_last);

    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        cnt_r[c]  <= 16'h0000;
        down_r[c] <= 1'b0;
      end else if (!ch_en_r[c]) begin
        cnt_r[c]  <= 16'h0000;
        down_r[c] <= 1'b0;
      end else if (tick[c]) begin
        if (period_end[c]) begin
          cnt_r[c]  <= 16'h0000;
          down_r[c] <= 1'b0;
        end else if (mode_r[c].center && at_top) begin
          cnt_r[c]  <= cnt_r[c] - 16'h0001;
          down_r[c] <= 1'b1;
        end else if (down_r[c]) begin
          cnt_r[c]  <= cnt_r[c] - 16'h0001;
        end else begin
          cnt_r[c]  <= cnt_r[c] + 16'h0001;
        end
      end
    end

    // Output: start level until duty match, opposite after
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        wave_r[c] <= 1'b0;
      end else if (!ch_en_r[c]) begin
        wave_r[c] <= mode_r[c].start_high;
      end else if (tick[c]) begin
        if (period_end[c]) begin
          wave_r[c] <= mode_r[c].start_high;
        end else if (up_hit) begin
          wave_r[c] <= ~mode_r[c].start_high;
        end else if (down_hit) begin
          wave_r[c] <= mode_r[c].start_high;
        end
      end
    end

    AST_UPD_AT_END: assert property (@(posedge CLOCK) disable iff (!NRST)
      (upd_pend_r[c] && !period_end[c]) |=> $stable(period_value_r[c])
        || !ch_en_r[c] || $past(bus.wr))
      else $error("Period changed mid-cycle");
    AST_CNT_LIMIT: assert property (@(posedge CLOCK) disable iff (!NRST)
      ch_en_r[c] && tick[c] && !mode_r[c].center && at_last
        |=> cnt_r[c] == 16'h0000)
      else $error("Left aligned counter did not wrap");
    AST_IDLE_LEVEL: assert property (@(posedge CLOCK) disable iff (!NRST)
      !ch_en_r[c] ##1 !ch_en_r[c]
        |-> wave_r[c] == $past(mode_r[c].start_high))
      else $error("Idle level differs from start level");
    AST_FROZEN: assert property (@(posedge CLOCK) disable iff (!NRST)
      !CLK_EN |=> $stable(cnt_r[c]) || !$past(ch_en_r[c]))
      else $error("Counter moved while clock gated");
    AST_CTR_TURN: assert property (@(posedge CLOCK) disable iff (!NRST)
      ch_en_r[c] && tick[c] && mode_r[c].center && at_top && !down_r[c]
        |=> down_r[c] && cnt_r[c] == $past(cnt_r[c]) - 16'h0001)
      else $error("Center aligned counter did not turn down");
    AST_WAVE_FLIP: assert property (@(posedge CLOCK) disable iff (!NRST)
      ch_en_r[c] && tick[c] && up_hit && !period_end[c]
        |=> wave_r[c] != mode_r[c].start_high)
      else $error("Output did not leave start level at duty match");
  end

  assign MODULATED_WAVE_OUT = wave_r;

  // Register writes; accepted regardless of CLK_EN
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      divider_config_reg_r <= fcpm_pkg::RST_ZERO;
    end else if (bus.wr && bus.addr == fcpm_pkg::OFS_DIVCFG) begin
      divider_config_reg_r <= bus.wdata & 32'h0FFF_0FFF;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ch_en_r <= '0;
    end else if (bus.wr && bus.addr == fcpm_pkg::OFS_ENA) begin
      ch_en_r <= ch_en_r | bus.wdata[NCH-1:0];
    end else if (bus.wr && bus.addr == fcpm_pkg::OFS_DIS) begin
      ch_en_r <= ch_en_r & ~bus.wdata[NCH-1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      channel_event_mask_r <= '0;
    end else if (bus.wr && bus.addr == fcpm_pkg::OFS_IEN) begin
      channel_event_mask_r <= channel_event_mask_r | bus.wdata[NCH-1:0];
    end else if (bus.wr && bus.addr == fcpm_pkg::OFS_IDIS) begin
      channel_event_mask_r <= channel_event_mask_r & ~bus.wdata[NCH-1:0];
    end
  end

  // Status read clears flags; a simultaneous event survives
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      channel_event_status_r <= '0;
    end else begin
      channel_event_status_r <= (bus.rd && bus.addr == fcpm_pkg::OFS_EVSTAT
        ? '0 : channel_event_status_r) | period_end;
    end
  end

  assign IRQ = |(channel_event_status_r &
                 channel_event_mask_r);

  for (genvar c = 0; c < NCH; c++) begin : g_chreg
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        mode_r[c] <= '0;
      end else if (bus.wr && ch_hit(bus.addr, c, fcpm_pkg::CH_MODE)) begin
        mode_r[c].sel <= bus.wdata[fcpm_pkg::SEL_LSB +: 4];
        mode_r[c].upd_period <= bus.wdata[fcpm_pkg::UPD_BIT];
        // Shape bits frozen while running to avoid a torn cycle
        if (!ch_en_r[c]) begin
          mode_r[c].center     <= bus.wdata[fcpm_pkg::ALIGN_BIT];
          mode_r[c].start_high <= bus.wdata[fcpm_pkg::POL_BIT];
        end
      end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        upd_hold_r[c] <= 16'h0000;
        upd_pend_r[c] <= 1'b0;
      end else if (bus.wr && ch_hit(bus.addr, c, fcpm_pkg::CH_UPDATE)) begin
        upd_hold_r[c] <= bus.wdata[CW-1:0];
        upd_pend_r[c] <= 1'b1;
      end else if (period_end[c] || !ch_en_r[c]) begin
        upd_pend_r[c] <= 1'b0;
      end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        period_value_r[c] <= 16'h0000;
        duty_value_r[c]   <= 16'h0000;
      end else if (bus.wr && !ch_en_r[c] &&
                   ch_hit(bus.addr, c, fcpm_pkg::CH_PERIOD)) begin
        period_value_r[c] <= bus.wdata[CW-1:0];
      end else if (bus.wr && !ch_en_r[c] &&
                   ch_hit(bus.addr, c, fcpm_pkg::CH_DUTY)) begin
        duty_value_r[c] <= bus.wdata[CW-1:0];
      end else if (upd_pend_r[c] && (period_end[c] || !ch_en_r[c])) begin
        if (mode_r[c].upd_period) begin
          period_value_r[c] <= upd_hold_r[c];
        end else begin
          duty_value_r[c] <= upd_hold_r[c];
        end
      end
    end
  end

  // Read mux, one cycle latency
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (bus.addr)
      fcpm_pkg::OFS_DIVCFG: rd_nxt = divider_config_reg_r;
      fcpm_pkg::OFS_STAT:   rd_nxt = 32'(ch_en_r);
      fcpm_pkg::OFS_IMASK:  rd_nxt = 32'(channel_event_mask_r);
      fcpm_pkg::OFS_EVSTAT: rd_nxt = 32'(channel_event_status_r);
      fcpm_pkg::OFS_CLKRUN: rd_nxt = 32'(CLK_EN);
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (ch_hit(bus.addr, c, fcpm_pkg::CH_MODE))
            rd_nxt = {21'h0, mode_r[c].upd_period, mode_r[c].start_high,
                      mode_r[c].center, 4'h0, mode_r[c].sel};
          if (ch_hit(bus.addr, c, fcpm_pkg::CH_DUTY))
            rd_nxt = {16'h0, duty_value_r[c]};
          if (ch_hit(bus.addr, c, fcpm_pkg::CH_PERIOD))
            rd_nxt = {16'h0, period_value_r[c]};
          if (ch_hit(bus.addr, c, fcpm_pkg::CH_UPDATE))
            rd_nxt = {16'h0, upd_hold_r[c]};
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 32'h0000_0000;
    end else if (bus.rd) begin
      RDATA <= rd_nxt;
    end
  end

  AST_IRQ_LEVEL: assert property (@(posedge CLOCK) disable iff (!NRST)
    (|(period_end & channel_event_mask_r)) &&
      !(bus.wr && bus.addr == fcpm_pkg::OFS_IDIS) |=> IRQ)
    else $error("Interrupt not raised at period end");
  AST_DIV_STOP: assert property (@(posedge CLOCK) disable iff (!NRST)
    lin_div[0] == 8'h00 |-> !lin_tick[0])
    else $error("Clock A ticks with zero factor");
  AST_GATE_PRE: assert property (@(posedge CLOCK) disable iff (!NRST)
    !CLK_EN |-> pre_tick == '0)
    else $error("Prescaler ticks while gated");
  AST_EN_SET: assert property (@(posedge CLOCK) disable iff (!NRST)
    bus.wr && bus.addr == fcpm_pkg::OFS_ENA && bus.wdata[0] && !ch_en_r[0]
      |=> ch_en_r[0] ##1 cnt_r[0] <= 16'h0001)
    else $error("Enable did not start channel from zero");
endmodule

// [test/fcpm_load.sv]
// Load model on one waveform pin: measures period and high time
`timescale 1ns/100ps
module fcpm_load (
  input  wire logic        clk,     // System clock, samples the pin
  input  wire logic        wave,    // Waveform pin under load
  output logic      [15:0] per_len, // Cycles between two rising edges
  output logic      [15:0] hi_len   // Cycles of the last high phase
);
  logic        prev_r = 1'b0;
  logic [15:0] since_r = 16'h0000;

  // Pure observer; a load never drives the pin back
  always @(posedge clk) begin
    since_r <= since_r + 16'h0001;
    if (wave && !prev_r) begin
      per_len <= since_r;
      since_r <= 16'h0001;
    end
    if (!wave && prev_r) begin
      hi_len <= since_r;
    end
    prev_r <= wave;
  end
endmodule

// [test/fcpm_top_test.sv]
// Self-checking bench for the four-channel pulse modulator
`timescale 1ns/100ps
module fcpm_top_test;
  localparam int NCH = fcpm_pkg::NCH;
  logic            clock;
  logic            nrst;
  logic            clk_en;
  logic [7:0]      addr;
  logic [31:0]     wdata;
  logic            wr;
  logic            rd;
  logic [31:0]     rdata;
  logic            irq;
  logic [NCH-1:0]  wave;
  logic [NCH-1:0]  held;
  logic [15:0]     per_len [NCH];
  logic [15:0]     hi_len [NCH];
  int              n_errors;
  int              n_checks;
  // Channel setups: mode word, period, duty, tick divisor, centered
  logic [31:0]     cmode [NCH] = '{32'h0, 32'hC, 32'h102, 32'hB};
  int              cper [NCH] = '{10, 8, 3, 5};
  int              cdut [NCH] = '{4, 2, 1, 1};
  int              cx [NCH] = '{1, 2, 4, 6};
  bit              cctr [NCH] = '{0, 0, 1, 0};

  fcpm_top #(.NCH(NCH)) u_fcpm_top (
    .CLOCK(clock), .NRST(nrst), .CLK_EN(clk_en), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
    .MODULATED_WAVE_OUT(wave)
  );

  for (genvar c = 0; c < NCH; c++) begin : g_load
    fcpm_load u_fcpm_load (
      .clk(clock), .wave(wave[c]), .per_len(per_len[c]),
      .hi_len(hi_len[c])
    );
  end

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  function automatic logic [7:0] chad(input int c, input logic [3:0] o);
    return fcpm_pkg::OFS_CH_BASE + 8'(c) * fcpm_pkg::OFS_CH_STEP + {4'h0, o};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk_reg(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_wave(input int c, input int x, input int p,
                          input int d, input bit ctr);
    int m;
    m = ctr ? 2 : 1;
    chk_reg($sformatf("period%0d", c), 32'(p * x * m), 32'(per_len[c]));
    chk_reg($sformatf("high%0d", c), 32'((p - d) * x * m), 32'(hi_len[c]));
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    chk_reg(what, exp, rdata);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    stop_test();
  end

  initial begin
    n_errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    idle(5);
    nrst <= 1'b1;
    rd_reg(fcpm_pkg::OFS_DIVCFG, 32'h0, "divcfg");
    rd_reg(fcpm_pkg::OFS_STAT, 32'h0, "enabled");
    rd_reg(fcpm_pkg::OFS_IMASK, 32'h0, "mask");
    rd_reg(8'h3C, 32'h0, "unmapped");
    rd_reg(fcpm_pkg::OFS_CLKRUN, 32'h1, "clkrun");
    chk_reg("waves", 32'h0, 32'(wave));
    $display("test reset done");
    wr_reg(fcpm_pkg::OFS_DIVCFG, 32'h0002_0103);
    rd_reg(fcpm_pkg::OFS_DIVCFG, 32'h0002_0103, "divcfg");
    for (int c = 0; c < NCH; c++) begin
      wr_reg(chad(c, fcpm_pkg::CH_MODE), cmode[c]);
      wr_reg(chad(c, fcpm_pkg::CH_PERIOD), 32'(cper[c]));
      wr_reg(chad(c, fcpm_pkg::CH_DUTY), 32'(cdut[c]));
    end
    wr_reg(fcpm_pkg::OFS_ENA, 32'hF);
    idle(100);
    for (int c = 0; c < NCH; c++) begin
      chk_wave(c, cx[c], cper[c], cdut[c], cctr[c]);
    end
    $display("test waveforms done");
    // Direct write while running must not reach the period
    wr_reg(chad(0, fcpm_pkg::CH_PERIOD), 32'd20);
    wr_reg(chad(0, fcpm_pkg::CH_UPDATE), 32'h7);
    wr_reg(fcpm_pkg::OFS_DIS, 32'h2);
    rd_reg(fcpm_pkg::OFS_STAT, 32'hD, "enabled");
    idle(60);
    chk_wave(0, 1, 10, 7, 0);
    wr_reg(chad(0, fcpm_pkg::CH_MODE), 32'h600);
    wr_reg(chad(0, fcpm_pkg::CH_UPDATE), 32'hC);
    idle(60);
    chk_wave(0, 1, 12, 7, 0);
    $display("test update done");
    clk_en <= 1'b0;
    idle(2);
    #1;
    held = wave;
    wr_reg(fcpm_pkg::OFS_DIVCFG, 32'h0002_0104);
    rd_reg(fcpm_pkg::OFS_DIVCFG, 32'h0002_0104, "divcfg");
    rd_reg(fcpm_pkg::OFS_CLKRUN, 32'h0, "clkrun");
    idle(20);
    #1;
    chk_reg("frozen", 32'(held), 32'(wave));
    @(posedge clock);
    clk_en <= 1'b1;
    idle(60);
    chk_wave(0, 1, 12, 7, 0);
    $display("test gating done");
    chk_reg("irq", 32'h0, 32'(irq));
    wr_reg(fcpm_pkg::OFS_IEN, 32'h1);
    idle(30);
    #1;
    chk_reg("irq", 32'h1, 32'(irq));
    rd_reg(fcpm_pkg::OFS_IMASK, 32'h1, "mask");
    wr_reg(fcpm_pkg::OFS_IDIS, 32'h1);
    #1;
    chk_reg("irq", 32'h0, 32'(irq));
    wr_reg(fcpm_pkg::OFS_IEN, 32'h1);
    #1;
    chk_reg("irq", 32'h1, 32'(irq));
    wr_reg(fcpm_pkg::OFS_DIS, 32'hF);
    rd_reg(fcpm_pkg::OFS_STAT, 32'h0, "enabled");
    rd_reg(fcpm_pkg::OFS_EVSTAT, 32'hF, "events");
    chk_reg("irq", 32'h0, 32'(irq));
    rd_reg(fcpm_pkg::OFS_EVSTAT, 32'h0, "events");
    $display("test interrupt done");
    wr_reg(chad(0, fcpm_pkg::CH_MODE), 32'h200);
    idle(1);
    #1;
    chk_reg("idle level", 32'h1, 32'(wave[0]));
    $display("test polarity done");
    stop_test();
  end
endmodule
